// file: bench/ctu_analog_model.sv
/*
  Behavioural stand-in for the analog current source and the converter.
  Assumes the control outputs of the unit are registered on i_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module ctu_analog_model
  import ctu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire ctu_analog_t i_analog,
  input wire logic i_converter_trigger,
  output var int o_trig_count,
  output var int o_charge_cycles
);
  // Converter starts once per trigger cycle; charge only flows while not grounded
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_trig_count <= 0;
      o_charge_cycles <= 0;
    end else begin
      if (i_converter_trigger) begin
        o_trig_count <= o_trig_count + 1;
      end
      if (i_analog.source_enable && !i_analog.discharge) begin
        o_charge_cycles <= o_charge_cycles + 1;
      end
    end
  end
endmodule : ctu_analog_model

`default_nettype wire

// file: bench/ctu_top_test.sv
/*
  Self-checking bench of the charge/time unit control logic.
  Assumes the register map and one-wait bus timing of the unit's package.
*/
`timescale 1ns/10ps
`default_nettype none

module ctu_top_test;
  import ctu_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic [3:0] src_lv = 4'h0;
  logic idle = 1'b0;
  ctu_analog_t analog;
  logic trig;
  logic irq;
  int trig_count;
  int charge_cycles;
  int failures = 0;
  int compares = 0;
  int seed = 64;
  int exp_trig = 0;
  logic [31:0] exp_q[$];
  logic [7:0] v;
  logic [1:0] s2;

  always #2 i_clk = ~i_clk;

  ctu_top u_ctu_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_edge_pin_one(src_lv[3]), .i_edge_pin_two(src_lv[2]),
    .i_capture_unit_one(src_lv[1]), .i_capture_unit_two(src_lv[0]), .i_idle(idle),
    .o_analog(analog), .o_converter_trigger(trig), .o_irq(irq));

  ctu_analog_model u_ctu_analog_model (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_analog(analog), .i_converter_trigger(trig), .o_trig_count(trig_count),
    .o_charge_cycles(charge_cycles));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= {24'h0, d};
    do @(posedge i_clk); while (waitreq !== 1'b0);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rd_exp(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask : rd_exp

  // Read results are compared in the cycle they stand on the bus
  always @(negedge i_clk) begin
    if (rd && waitreq === 1'b0 && exp_q.size() > 0) begin
      chk("readdata", exp_q.pop_front(), rdata);
    end
  end

  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #50000;
    failures++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd_exp(CTU_OFF_CTRL_HI, CTU_RST_CTRL_HI);
    rd_exp(CTU_OFF_CTRL_LO, CTU_RST_CTRL_LO);
    rd_exp(CTU_OFF_ICON, CTU_RST_ICON);
    rd_exp(CTU_OFF_IRQ, 8'h00);
    rd_exp(4'h2, 8'h00);
    bus(1'b1, 4'h2, 8'h5A);
    bus(1'b1, CTU_OFF_CTRL_LO, 8'h90);
    bus(1'b1, CTU_OFF_CTRL_HI, 8'hFF);
    rd_exp(CTU_OFF_CTRL_HI, 8'hBF);
    repeat (3) @(posedge i_clk);
    chk("discharge", 1'b1, analog.discharge);
    chk("delay_gen", 1'b1, analog.delay_generation);
    bus(1'b1, CTU_OFF_CTRL_HI, 8'h80);
    repeat (3) @(posedge i_clk);
    chk("discharge off", 1'b0, analog.discharge);
    chk("delay_gen off", 1'b0, analog.delay_generation);
    for (int r = 0; r < 4; r++) begin
      v = {6'($random(seed)), 2'(r)};
      bus(1'b1, CTU_OFF_ICON, v);
      rd_exp(CTU_OFF_ICON, v);
      repeat (3) @(posedge i_clk);
      chk("trim", v[7:2], $unsigned(analog.current_trim));
      chk("ranges", {r == 3, r == 2, r == 1}, {analog.range_x100, analog.range_x10,
        analog.range_base});
    end
    // Blocked: gate off, idle stop while idle, unit disabled
    idle <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, CTU_OFF_CTRL_HI, i == 0 ? 8'h80 : (i == 1 ? 8'hA8 : 8'h08));
      src_lv <= 4'hF;
      repeat (8) @(posedge i_clk);
      rd_exp(CTU_OFF_CTRL_LO, 8'h90);
      src_lv <= 4'h0;
    end
    idle <= 1'b0;
    bus(1'b1, CTU_OFF_IRQ, 8'h02);
    for (int s = 0; s < 4; s++) begin
      s2 = 2'(s + 1);
      bus(1'b1, CTU_OFF_CTRL_HI, 8'h88 | 8'(s[0]));
      bus(1'b1, CTU_OFF_CTRL_LO, {1'b1, s2, 1'b1, 2'(s), 2'b00});
      src_lv[s] <= 1'b1;
      repeat (8) @(posedge i_clk);
      chk("source on", 1'b1, analog.source_enable);
      rd_exp(CTU_OFF_CTRL_LO, {1'b1, s2, 1'b1, 2'(s), 2'b01});
      src_lv[s2] <= 1'b1;
      repeat (8) @(posedge i_clk);
      exp_trig += s % 2;
      chk("trigger count", exp_trig, trig_count);
      chk("source off", 1'b0, analog.source_enable);
      chk("irq", 1'b1, irq);
      rd_exp(CTU_OFF_CTRL_LO, {1'b1, s2, 1'b1, 2'(s), 2'b11});
      rd_exp(CTU_OFF_IRQ, 8'h03);
      src_lv <= 4'h0;
      bus(1'b1, CTU_OFF_IRQ, 8'h03);
      bus(1'b1, CTU_OFF_CTRL_LO, 8'h90);
      repeat (3) @(posedge i_clk);
      chk("irq cleared", 1'b0, irq);
    end
    // Order mode: channel two level first must not count
    bus(1'b1, CTU_OFF_CTRL_HI, 8'h8C);
    bus(1'b1, CTU_OFF_CTRL_LO, 8'hBC);
    src_lv[1] <= 1'b1;
    repeat (8) @(posedge i_clk);
    rd_exp(CTU_OFF_CTRL_LO, 8'hBC);
    src_lv[3] <= 1'b1;
    repeat (8) @(posedge i_clk);
    rd_exp(CTU_OFF_CTRL_LO, 8'hBF);
    src_lv <= 4'h0;
    // Let the pin synchroniser drain so the old match cannot re-set a flag
    repeat (6) @(posedge i_clk);
    bus(1'b1, CTU_OFF_CTRL_LO, 8'h92);
    repeat (3) @(posedge i_clk);
    chk("sw flag source", 1'b1, analog.source_enable);
    rd_exp(CTU_OFF_CTRL_LO, 8'h92);
    chk("charge seen", 1'b1, charge_cycles > 0);
    repeat (4) @(posedge i_clk);
    end_sim();
  end
endmodule : ctu_top_test

`default_nettype wire

// file: rtl/ctu_pkg.sv
/*
  Constants, register map and carrier types of the charge/time unit control logic.
  Assumes an Avalon-MM master with 32-bit data and byte addressing.
*/
package ctu_pkg;

  // Register byte offsets
  localparam logic [3:0] CTU_OFF_CTRL_HI = 4'h0;
  localparam logic [3:0] CTU_OFF_CTRL_LO = 4'h4;
  localparam logic [3:0] CTU_OFF_ICON = 4'h8;
  localparam logic [3:0] CTU_OFF_IRQ = 4'hC;

  // Reset values
  localparam logic [7:0] CTU_RST_CTRL_HI = 8'h00;
  localparam logic [7:0] CTU_RST_CTRL_LO = 8'h00;
  localparam logic [7:0] CTU_RST_ICON = 8'h00;
  localparam logic [1:0] CTU_RST_IRQ = 2'h0;

  // High control register fields
  localparam int CTU_HI_UNIT_ENABLE = 7;
  localparam int CTU_HI_RESERVED = 6;
  localparam int CTU_HI_IDLE_STOP = 5;
  localparam int CTU_HI_DELAY_GEN = 4;
  localparam int CTU_HI_EDGE_GATE = 3;
  localparam int CTU_HI_EDGE_ORDER = 2;
  localparam int CTU_HI_DISCHARGE = 1;
  localparam int CTU_HI_CONV_TRIG = 0;

  // Low control register fields
  localparam int CTU_LO_CHAN2_POL = 7;
  localparam int CTU_LO_CHAN2_SEL_HI = 6;
  localparam int CTU_LO_CHAN2_SEL_LO = 5;
  localparam int CTU_LO_CHAN1_POL = 4;
  localparam int CTU_LO_CHAN1_SEL_HI = 3;
  localparam int CTU_LO_CHAN1_SEL_LO = 2;
  localparam int CTU_LO_CHAN2_FLAG = 1;
  localparam int CTU_LO_CHAN1_FLAG = 0;

  // Current register fields
  localparam int CTU_IC_TRIM_HI = 7;
  localparam int CTU_IC_TRIM_LO = 2;
  localparam int CTU_IC_RANGE_HI = 1;
  localparam int CTU_IC_RANGE_LO = 0;

  // Interrupt register fields
  localparam int CTU_IRQ_FLAG = 0;
  localparam int CTU_IRQ_ENABLE = 1;

  // Channel source encodings
  localparam logic [1:0] CTU_SRC_PIN_ONE = 2'h3;
  localparam logic [1:0] CTU_SRC_PIN_TWO = 2'h2;
  localparam logic [1:0] CTU_SRC_CAPTURE_ONE = 2'h1;
  localparam logic [1:0] CTU_SRC_CAPTURE_TWO = 2'h0;

  // Current range encodings
  localparam logic [1:0] CTU_RANGE_X100 = 2'h3;
  localparam logic [1:0] CTU_RANGE_X10 = 2'h2;
  localparam logic [1:0] CTU_RANGE_BASE = 2'h1;
  localparam logic [1:0] CTU_RANGE_OFF = 2'h0;

  typedef struct packed {
    logic source_enable;
    logic discharge;
    logic delay_generation;
    logic signed [5:0] current_trim;
    logic range_x100;
    logic range_x10;
    logic range_base;
  } ctu_analog_t;

endpackage : ctu_pkg

// file: rtl/ctu_top.sv
/*
  Control logic of the charge/time unit: registers on Avalon-MM, edge channels,
  status flags, current source gating, converter trigger and event flag.
  Assumes edge pins are asynchronous; capture triggers and idle come from i_clk logic.
*/
// The Avalon-MM interface to the registers and the register offsets were decided locally.
// Operation
// - High bit 7 enables the whole measurement unit; discharge, trim and range outputs follow their bits even while it is clear.
// - High bit 6 reads zero and ignores writes.
// - High bit 5 set blocks edges, the current source and delay generation while the chip idles.
// - High bit 4 selects delay generation, else measurement mode.
// - High bit 3 clear blocks edges on both channels.
// - High bit 2 set lets channel two act only after channel one.
// - High bit 1 grounds the current source output.
// - High bit 0 enables the converter trigger output.
// - Low bit 7 picks channel two polarity, one high, zero low.
// - Low bits 6-5 pick channel two source among pins and triggers.
// - Low bit 4 picks channel one polarity, one high, zero low.
// - Low bits 3-2 pick channel one source, same encoding.
// - Low bit 1 records a channel two event.
// - Low bit 0 records a channel one event.
// - Current bits 7-2 are a signed trim, zero nominal.
// - Current bits 1-0 select hundred, ten, base or off.
// - Edge inputs act by level, from four possible sources.
// - Current source on only while exactly one flag is set.
// - A flag sets as soon as level matches polarity.
// - Software may set or clear either flag directly.
// - Source turning off raises the event flag, masked to the request.
`timescale 1ns/10ps
`default_nettype none

module ctu_top
  import ctu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_edge_pin_one,
  input wire logic i_edge_pin_two,
  input wire logic i_capture_unit_one,
  input wire logic i_capture_unit_two,
  input wire logic i_idle,
  output ctu_analog_t o_analog,
  output logic o_converter_trigger,
  output logic o_irq
);

  function automatic logic pick_source(input logic [1:0] sel, input logic pin_one,
                                       input logic pin_two, input logic cap_one,
                                       input logic cap_two);
    logic v;
    v = cap_two;
    case (sel)
      CTU_SRC_PIN_ONE: v = pin_one;
      CTU_SRC_PIN_TWO: v = pin_two;
      CTU_SRC_CAPTURE_ONE: v = cap_one;
      default: v = cap_two;
    endcase
    return v;
  endfunction : pick_source

  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] hi_q;
  logic [7:2] lo_cfg_q;
  logic flag1_q;
  logic flag2_q;
  logic flag1_d;
  logic flag2_d;
  logic [7:0] icon_q;
  logic irq_flag_q;
  logic irq_en_q;
  logic trig_q;
  ctu_analog_t analog_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_f_q;
  logic req;
  logic wr_go;
  logic wr_hi;
  logic wr_lo;
  logic wr_ic;
  logic wr_irq;
  logic running;
  logic edges_ok;
  logic level1;
  logic level2;
  logic match1;
  logic match2;
  logic set1;
  logic set2;
  logic src_d;
  logic [7:0] rd_byte;

  // Bus slave: one wait cycle, write and read answer at the second edge
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign o_avs_readdata = rdata_q;
  assign wr_go = i_avs_write & ack_q & i_avs_byteenable[0];
  assign wr_hi = wr_go & (i_avs_address == CTU_OFF_CTRL_HI);
  assign wr_lo = wr_go & (i_avs_address == CTU_OFF_CTRL_LO);
  assign wr_ic = wr_go & (i_avs_address == CTU_OFF_ICON);
  assign wr_irq = wr_go & (i_avs_address == CTU_OFF_IRQ);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (i_avs_address)
      CTU_OFF_CTRL_HI: rd_byte = hi_q;
      CTU_OFF_CTRL_LO: rd_byte = {lo_cfg_q, flag2_q, flag1_q};
      CTU_OFF_ICON: rd_byte = icon_q;
      CTU_OFF_IRQ: rd_byte = {6'h00, irq_en_q, irq_flag_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  // Control registers; the reserved bit is never stored
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_q <= CTU_RST_CTRL_HI;
    end else if (wr_hi) begin
      hi_q <= i_avs_writedata[7:0] & 8'hBF;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_cfg_q <= CTU_RST_CTRL_LO[7:2];
      icon_q <= CTU_RST_ICON;
    end else begin
      if (wr_lo) begin
        lo_cfg_q <= i_avs_writedata[7:2];
      end
      if (wr_ic) begin
        icon_q <= i_avs_writedata[7:0];
      end
    end
  end

  // Pin synchronisers; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pin_s1_q[gi] <= 1'b0;
          pin_s2_q[gi] <= 1'b0;
          pin_s3_q[gi] <= 1'b0;
          pin_f_q[gi] <= 1'b0;
        end else begin
          pin_s1_q[gi] <= (gi == 0) ? i_edge_pin_one : i_edge_pin_two;
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_f_q[gi] <= pin_s3_q[gi];
          end
        end
      end
    end
  endgenerate

  // Edge channels, evaluated by level
  assign running = hi_q[CTU_HI_UNIT_ENABLE] &
                   ~(hi_q[CTU_HI_IDLE_STOP] & i_idle);
  assign edges_ok = running & hi_q[CTU_HI_EDGE_GATE];
  assign level1 = pick_source(lo_cfg_q[CTU_LO_CHAN1_SEL_HI:CTU_LO_CHAN1_SEL_LO],
                              pin_f_q[0], pin_f_q[1], i_capture_unit_one,
                              i_capture_unit_two);
  assign level2 = pick_source(lo_cfg_q[CTU_LO_CHAN2_SEL_HI:CTU_LO_CHAN2_SEL_LO],
                              pin_f_q[0], pin_f_q[1], i_capture_unit_one,
                              i_capture_unit_two);
  assign match1 = (level1 == lo_cfg_q[CTU_LO_CHAN1_POL]);
  assign match2 = (level2 == lo_cfg_q[CTU_LO_CHAN2_POL]);
  assign set1 = edges_ok & match1;
  assign set2 = edges_ok & match2 &
                (~hi_q[CTU_HI_EDGE_ORDER] | flag1_q);

  // Status flags: software writes them, a hardware set wins
  assign flag1_d = (wr_lo ? i_avs_writedata[CTU_LO_CHAN1_FLAG] : flag1_q) | set1;
  assign flag2_d = (wr_lo ? i_avs_writedata[CTU_LO_CHAN2_FLAG] : flag2_q) | set2;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag1_q <= CTU_RST_CTRL_LO[CTU_LO_CHAN1_FLAG];
      flag2_q <= CTU_RST_CTRL_LO[CTU_LO_CHAN2_FLAG];
    end else begin
      flag1_q <= flag1_d;
      flag2_q <= flag2_d;
    end
  end

  // Analog controls
  assign src_d = (flag1_q ^ flag2_q) & running;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      analog_q <= '0;
    end else begin
      analog_q.source_enable <= src_d;
      analog_q.discharge <= hi_q[CTU_HI_DISCHARGE];
      analog_q.delay_generation <= hi_q[CTU_HI_DELAY_GEN] & running;
      analog_q.current_trim <= $signed(icon_q[CTU_IC_TRIM_HI:CTU_IC_TRIM_LO]);
      analog_q.range_x100 <= (icon_q[CTU_IC_RANGE_HI:CTU_IC_RANGE_LO] == CTU_RANGE_X100);
      analog_q.range_x10 <= (icon_q[CTU_IC_RANGE_HI:CTU_IC_RANGE_LO] == CTU_RANGE_X10);
      analog_q.range_base <= (icon_q[CTU_IC_RANGE_HI:CTU_IC_RANGE_LO] == CTU_RANGE_BASE);
    end
  end
  assign o_analog = analog_q;

  // Converter trigger pulse on channel two flag rising
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= flag2_d & ~flag2_q & hi_q[CTU_HI_CONV_TRIG] &
                hi_q[CTU_HI_UNIT_ENABLE];
    end
  end
  assign o_converter_trigger = trig_q;

  // Event flag: set on source falling, write one clears, set wins
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_flag_q <= CTU_RST_IRQ[CTU_IRQ_FLAG];
      irq_en_q <= CTU_RST_IRQ[CTU_IRQ_ENABLE];
    end else begin
      irq_flag_q <= (analog_q.source_enable & ~src_d) |
                    (irq_flag_q & ~(wr_irq & i_avs_writedata[CTU_IRQ_FLAG]));
      if (wr_irq) begin
        irq_en_q <= i_avs_writedata[CTU_IRQ_ENABLE];
      end
    end
  end
  assign o_irq = irq_flag_q & irq_en_q;

  // Checks
  sequence s_hi_read_done;
    i_avs_read && !o_avs_waitrequest && (i_avs_address == CTU_OFF_CTRL_HI);
  endsequence

  sequence s_flag2_rise;
    !flag2_q ##1 flag2_q;
  endsequence

  property p_reserved_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
      s_hi_read_done |-> (o_avs_readdata[CTU_HI_RESERVED] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved high bit read as one");

  property p_one_wait;
    @(posedge i_clk) disable iff (!i_rst_n)
      (req && o_avs_waitrequest) |=> !o_avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not after one wait cycle");

  property p_blocked;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!edges_ok && !wr_lo && !flag1_q) |=> !flag1_q;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("channel one flag set while edges blocked");

  property p_order;
    @(posedge i_clk) disable iff (!i_rst_n)
      (hi_q[CTU_HI_EDGE_ORDER] && !flag1_q && !flag2_q && !wr_lo) |=> !flag2_q;
  endproperty
  a_order: assert property (p_order)
    else $error("channel two flag set before channel one");

  property p_level_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      (edges_ok && match1) |=> flag1_q;
  endproperty
  a_level_set: assert property (p_level_set)
    else $error("matching level did not set channel one flag");

  property p_source_xor;
    @(posedge i_clk) disable iff (!i_rst_n)
      ##1 (o_analog.source_enable == ($past(flag1_q ^ flag2_q) && $past(running)));
  endproperty
  a_source_xor: assert property (p_source_xor)
    else $error("source enable not exclusive-or of flags");

  property p_trigger;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_flag2_rise ##0 $past(hi_q[CTU_HI_CONV_TRIG] && hi_q[CTU_HI_UNIT_ENABLE]))
        |-> o_converter_trigger ##1 !o_converter_trigger;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("trigger pulse missing or too long");

  property p_event_flag;
    @(posedge i_clk) disable iff (!i_rst_n)
      $fell(o_analog.source_enable) |-> irq_flag_q;
  endproperty
  a_event_flag: assert property (p_event_flag)
    else $error("event flag not set when source turned off");

  property p_range;
    @(posedge i_clk) disable iff (!i_rst_n)
      ##1 (o_analog.range_x100 == ($past(icon_q[1:0]) == CTU_RANGE_X100)) &&
          ((o_analog.range_x100 | o_analog.range_x10 | o_analog.range_base) ==
           ($past(icon_q[1:0]) != CTU_RANGE_OFF));
  endproperty
  a_range: assert property (p_range)
    else $error("current range decode wrong");

endmodule : ctu_top

`default_nettype wire
